// *** inc/mcs_pkg.sv ***
// Constants, types and helpers shared by the motion card safety supervisor
package mcs_pkg;

	// -----------------------------------------------------------------
	// Clock and timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * CLK_MHZ * 1000;
	localparam int unsigned CAN_IDLE_MS   = 10;
	localparam int unsigned CAN_IDLE_CYC  = CAN_IDLE_MS * CLK_MHZ * 1000;
	localparam int unsigned NODE_DROP_US  = 1000;
	localparam int unsigned NODE_DROP_CYC = NODE_DROP_US * CLK_MHZ;

	// -----------------------------------------------------------------
	// Sizes
	// -----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned NUM_JOINTS = 6;
	localparam int unsigned NUM_PWR    = 7;
	localparam int unsigned NUM_NODES  = 16;
	localparam int unsigned NUM_ESTOP  = 2;
	localparam int unsigned SW_STRIDE  = 3;
	localparam int unsigned SW_BITS    = NUM_JOINTS * SW_STRIDE;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_TIMEOUT = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_SW_TRUE = 8'h0C;
	localparam logic [7:0] REG_SW_INV  = 8'h10;
	localparam logic [7:0] REG_ESTOP   = 8'h14;
	localparam logic [7:0] REG_NODES   = 8'h18;

	// -----------------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------------
	localparam int unsigned CTRL_WDOG_EN = 0;
	localparam int unsigned CTRL_PWR_REQ = 1;
	localparam int unsigned CTRL_RUN     = 2;
	localparam logic [2:0]  CTRL_RST     = 3'h0;
	localparam int unsigned ST_EXPIRED   = 0;
	localparam int unsigned ST_PWR_ON    = 1;
	localparam int unsigned ST_PWR_FAULT = 2;
	localparam int unsigned ST_PCI_ERR   = 3;
	localparam int unsigned ST_BOOTED    = 4;
	localparam int unsigned SW_LOW       = 0;
	localparam int unsigned SW_HIGH      = 1;
	localparam int unsigned SW_ORG       = 2;
	localparam int unsigned ESTOP_INV    = 2;
	localparam int unsigned NODES_DROP   = 16;
	localparam logic [31:0] TIMEOUT_RST  = 32'h0003_D090;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		WD_OFF = 2'b00,
		WD_RUN = 2'b01,
		WD_EXP = 2'b10
	} mcs_wd_t;

	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_ON    = 2'b01,
		LED_BLINK = 2'b10
	} mcs_led_t;

	// Lamp level from display mode and blink phase
	function automatic logic led_level(mcs_led_t mode, logic phase);
		return (mode == LED_ON) || ((mode == LED_BLINK) && phase);
	endfunction

endpackage

// *** core/mcs_node_track.sv ***
// RS485 expander node presence tracker, one slot per node address
`timescale 1ns/10ps
module mcs_node_track #(
	parameter int unsigned DROP_CYC = mcs_pkg::NODE_DROP_CYC
) (
	// Clock and reset
	input  wire logic                           clk_sys_in,
	input  wire logic                           nrst_in,
	// Bus activity
	input  wire logic                           init_busy_in,
	input  wire logic [mcs_pkg::NUM_NODES-1:0]  answer_in,
	// Node state
	output logic      [mcs_pkg::NUM_NODES-1:0]  active_out,
	output logic      [mcs_pkg::NUM_NODES-1:0]  dropped_out
);

	logic [31:0] silent_ff [mcs_pkg::NUM_NODES];
	logic [mcs_pkg::NUM_NODES-1:0] active_ff;
	logic [mcs_pkg::NUM_NODES-1:0] dropped_ff;

	// ------------------------------------------------------------------
	// Per node recognition and drop
	// ------------------------------------------------------------------
	// Slot index is the node's four-bit address
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			active_ff  <= '0;
			dropped_ff <= '0;
			for (int i = 0; i < mcs_pkg::NUM_NODES; i++) begin
				silent_ff[i] <= 32'h0000_0000;
			end
		end else begin
			for (int i = 0; i < mcs_pkg::NUM_NODES; i++) begin
				if (answer_in[i]) begin
					silent_ff[i] <= 32'h0000_0000;
				end else if (active_ff[i]) begin
					silent_ff[i] <= silent_ff[i] + 32'h0000_0001;
				end
				// Any answering node joins during init
				if (init_busy_in && answer_in[i]) begin
					active_ff[i]  <= 1'b1;
					dropped_ff[i] <= 1'b0;
				end else if (active_ff[i] && !answer_in[i] &&
						silent_ff[i] >= DROP_CYC - 1) begin
					active_ff[i]  <= 1'b0;
					dropped_ff[i] <= 1'b1;
				end
			end
		end
	end

	assign active_out  = active_ff;
	assign dropped_out = dropped_ff;

endmodule // mcs_node_track

// *** core/mcs_supervisor.sv ***
// Safety supervisor of the six-axis motion card: watchdog, switches, LEDs
`timescale 1ns/10ps
module mcs_supervisor #(
	parameter int unsigned BLINK_CYC     = mcs_pkg::BLINK_CYC,
	parameter int unsigned CAN_IDLE_CYC  = mcs_pkg::CAN_IDLE_CYC,
	parameter int unsigned NODE_DROP_CYC = mcs_pkg::NODE_DROP_CYC
) (
	// Clock and reset
	input  wire logic                              clk_sys_in,
	input  wire logic                              nrst_in,
	// Register port
	input  wire logic [mcs_pkg::ADDR_W-1:0]        addr_in,
	input  wire logic [mcs_pkg::DATA_W-1:0]        wdata_in,
	input  wire logic                              wr_in,
	input  wire logic                              rd_in,
	output logic      [mcs_pkg::DATA_W-1:0]        rdata_out,
	// Switch and fault inputs
	input  wire logic [mcs_pkg::NUM_JOINTS-1:0]    low_travel_limit_level_in,
	input  wire logic [mcs_pkg::NUM_JOINTS-1:0]    high_travel_limit_level_in,
	input  wire logic [mcs_pkg::NUM_JOINTS-1:0]    origin_switch_level_in,
	input  wire logic [mcs_pkg::NUM_ESTOP-1:0]     estop_level_in,
	input  wire logic                              pwr_fault_in,
	// Status sources
	input  wire logic                              pci_err_in,
	input  wire logic                              can_frame_in,
	input  wire logic                              can_buf_full_in,
	input  wire logic                              boot_done_in,
	input  wire logic                              node_init_busy_in,
	input  wire logic [mcs_pkg::NUM_NODES-1:0]     node_answer_in,
	// Power enables, axis 0..5 then CAN
	output logic      [mcs_pkg::NUM_PWR-1:0]       pwr_en_out,
	output logic                                   wdog_expired_out,
	// Lamps
	output logic                                   led_can_out,
	output logic                                   led_rs485_out,
	output logic                                   led_run_out,
	output logic                                   led_boot_out,
	output logic                                   led_err_out
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [2:0]                       ctrl_ff;
	logic [31:0]                      timeout_ff;
	logic [31:0]                      wd_cnt_ff;
	logic [31:0]                      nxt_wd_cnt;
	mcs_pkg::mcs_wd_t                 wd_st_ff;
	mcs_pkg::mcs_wd_t                 nxt_wd_st;
	logic                             host_read_service;
	logic                             pci_err_ff;
	logic [mcs_pkg::SW_BITS-1:0]      sw_snap_ff;
	logic [mcs_pkg::SW_BITS-1:0]      nxt_sw_snap;
	logic [mcs_pkg::NUM_ESTOP-1:0]    estop_snap_ff;
	logic [mcs_pkg::NUM_PWR-1:0]      pwr_en_ff;
	logic                             expired_ff;
	logic [mcs_pkg::DATA_W-1:0]       rdata_ff;
	logic [mcs_pkg::DATA_W-1:0]       nxt_rdata;
	logic [31:0]                      blink_cnt_ff;
	logic                             blink_ff;
	logic [31:0]                      can_idle_ff;
	logic                             led_can_ff;
	logic                             led_rs485_ff;
	logic                             led_run_ff;
	logic                             led_boot_ff;
	logic                             led_err_ff;
	logic [mcs_pkg::NUM_NODES-1:0]    node_active;
	logic [mcs_pkg::NUM_NODES-1:0]    node_dropped;
	mcs_pkg::mcs_led_t                can_mode;
	mcs_pkg::mcs_led_t                rs485_mode;
	mcs_pkg::mcs_led_t                err_mode;
	mcs_pkg::mcs_led_t                run_mode;
	logic                             pwr_ok;

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// Control and timeout registers
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_ff    <= mcs_pkg::CTRL_RST;
			timeout_ff <= mcs_pkg::TIMEOUT_RST;
		end else if (wr_in) begin
			if (addr_in == mcs_pkg::REG_CTRL) begin
				ctrl_ff <= wdata_in[2:0];
			end
			if (addr_in == mcs_pkg::REG_TIMEOUT) begin
				timeout_ff <= wdata_in;
			end
		end
	end

	// Host bus error flag, a new error beats the clear
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pci_err_ff <= 1'b0;
		end else if (pci_err_in) begin
			pci_err_ff <= 1'b1;
		end else if (wr_in && addr_in == mcs_pkg::REG_STATUS &&
				wdata_in[mcs_pkg::ST_PCI_ERR]) begin
			pci_err_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------------
	// Reading the status word is the periodic service
	assign host_read_service = rd_in && (addr_in == mcs_pkg::REG_STATUS);

	// Next state and count
	always_comb begin
		nxt_wd_st  = wd_st_ff;
		nxt_wd_cnt = wd_cnt_ff;
		unique case (wd_st_ff)
			mcs_pkg::WD_OFF: begin
				nxt_wd_cnt = 32'h0000_0000;
				if (ctrl_ff[mcs_pkg::CTRL_WDOG_EN]) begin
					nxt_wd_st = mcs_pkg::WD_RUN;
				end
			end
			mcs_pkg::WD_RUN: begin
				if (!ctrl_ff[mcs_pkg::CTRL_WDOG_EN]) begin
					nxt_wd_st  = mcs_pkg::WD_OFF;
					nxt_wd_cnt = 32'h0000_0000;
				end else if (host_read_service) begin
					nxt_wd_cnt = 32'h0000_0000;
				end else if (wd_cnt_ff >= timeout_ff) begin
					nxt_wd_st = mcs_pkg::WD_EXP;
				end else begin
					nxt_wd_cnt = wd_cnt_ff + 32'h0000_0001;
				end
			end
			mcs_pkg::WD_EXP: begin
				// Held until software drops the enable
				if (!ctrl_ff[mcs_pkg::CTRL_WDOG_EN]) begin
					nxt_wd_st  = mcs_pkg::WD_OFF;
					nxt_wd_cnt = 32'h0000_0000;
				end
			end
			default: begin
				nxt_wd_st  = mcs_pkg::WD_OFF;
				nxt_wd_cnt = 32'h0000_0000;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wd_st_ff  <= mcs_pkg::WD_OFF;
			wd_cnt_ff <= 32'h0000_0000;
		end else begin
			wd_st_ff  <= nxt_wd_st;
			wd_cnt_ff <= nxt_wd_cnt;
		end
	end

	// ------------------------------------------------------------------
	// Power enables
	// ------------------------------------------------------------------
	// Uses next state so overrun drops power on the same edge
	assign pwr_ok = ctrl_ff[mcs_pkg::CTRL_PWR_REQ] && !pwr_fault_in &&
		(nxt_wd_st != mcs_pkg::WD_EXP);

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwr_en_ff  <= '0;
			expired_ff <= 1'b0;
		end else begin
			pwr_en_ff  <= {mcs_pkg::NUM_PWR{pwr_ok}};
			expired_ff <= (nxt_wd_st == mcs_pkg::WD_EXP);
		end
	end

	// ------------------------------------------------------------------
	// Switch sampling
	// ------------------------------------------------------------------
	// Interleave low, high and origin per joint
	always_comb begin
		nxt_sw_snap = '0;
		for (int j = 0; j < mcs_pkg::NUM_JOINTS; j++) begin
			nxt_sw_snap[j*mcs_pkg::SW_STRIDE + mcs_pkg::SW_LOW] =
				low_travel_limit_level_in[j];
			nxt_sw_snap[j*mcs_pkg::SW_STRIDE + mcs_pkg::SW_HIGH] =
				high_travel_limit_level_in[j];
			nxt_sw_snap[j*mcs_pkg::SW_STRIDE + mcs_pkg::SW_ORG] =
				origin_switch_level_in[j];
		end
	end

	// Snapshot taken at every service read
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sw_snap_ff    <= '0;
			estop_snap_ff <= '0;
		end else if (host_read_service) begin
			sw_snap_ff    <= nxt_sw_snap;
			estop_snap_ff <= estop_level_in;
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	// Unmapped addresses and idle cycles read zero
	always_comb begin
		nxt_rdata = '0;
		if (rd_in) begin
			unique case (addr_in)
				mcs_pkg::REG_CTRL: nxt_rdata[2:0] = ctrl_ff;
				mcs_pkg::REG_TIMEOUT: nxt_rdata = timeout_ff;
				mcs_pkg::REG_STATUS: begin
					nxt_rdata[mcs_pkg::ST_EXPIRED]   = expired_ff;
					nxt_rdata[mcs_pkg::ST_PWR_ON]    = pwr_en_ff[0];
					nxt_rdata[mcs_pkg::ST_PWR_FAULT] = pwr_fault_in;
					nxt_rdata[mcs_pkg::ST_PCI_ERR]   = pci_err_ff;
					nxt_rdata[mcs_pkg::ST_BOOTED]    = led_boot_ff;
				end
				mcs_pkg::REG_SW_TRUE:
					nxt_rdata[mcs_pkg::SW_BITS-1:0] = sw_snap_ff;
				mcs_pkg::REG_SW_INV:
					nxt_rdata[mcs_pkg::SW_BITS-1:0] = ~sw_snap_ff;
				mcs_pkg::REG_ESTOP: begin
					nxt_rdata[1:0] = estop_snap_ff;
					nxt_rdata[mcs_pkg::ESTOP_INV +: 2] = ~estop_snap_ff;
				end
				mcs_pkg::REG_NODES: begin
					nxt_rdata[15:0] = node_active;
					nxt_rdata[mcs_pkg::NODES_DROP +: 16] = node_dropped;
				end
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------------
	// RS485 nodes
	// ------------------------------------------------------------------
	// Presence and drop per node address
	mcs_node_track #(
		.DROP_CYC     (NODE_DROP_CYC)
	) u_nodes (
		.clk_sys_in   (clk_sys_in),
		.nrst_in      (nrst_in),
		.init_busy_in (node_init_busy_in),
		.answer_in    (node_answer_in),
		.active_out   (node_active),
		.dropped_out  (node_dropped)
	);

	// ------------------------------------------------------------------
	// Lamps
	// ------------------------------------------------------------------
	// Common blink phase
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= 1'b0;
		end else if (blink_cnt_ff >= BLINK_CYC - 1) begin
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= !blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
		end
	end

	// CAN traffic window, retriggered by each frame
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			can_idle_ff <= 32'h0000_0000;
		end else if (can_frame_in) begin
			can_idle_ff <= CAN_IDLE_CYC;
		end else if (can_idle_ff != 32'h0000_0000) begin
			can_idle_ff <= can_idle_ff - 32'h0000_0001;
		end
	end

	// Display modes per lamp
	always_comb begin
		can_mode = mcs_pkg::LED_OFF;
		if (can_buf_full_in) begin
			can_mode = mcs_pkg::LED_ON;
		end else if (can_idle_ff != 32'h0000_0000) begin
			can_mode = mcs_pkg::LED_BLINK;
		end
		rs485_mode = mcs_pkg::LED_OFF;
		if (|node_dropped) begin
			rs485_mode = mcs_pkg::LED_OFF;
		end else if (node_init_busy_in) begin
			rs485_mode = mcs_pkg::LED_BLINK;
		end else if (|node_active) begin
			rs485_mode = mcs_pkg::LED_ON;
		end
		err_mode = mcs_pkg::LED_OFF;
		if (wd_st_ff == mcs_pkg::WD_EXP) begin
			err_mode = mcs_pkg::LED_ON;
		end else if (pci_err_ff) begin
			err_mode = mcs_pkg::LED_BLINK;
		end
		run_mode = ctrl_ff[mcs_pkg::CTRL_RUN] ? mcs_pkg::LED_BLINK :
			mcs_pkg::LED_OFF;
	end

	// Lamp flops
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			led_can_ff   <= 1'b0;
			led_rs485_ff <= 1'b0;
			led_run_ff   <= 1'b0;
			led_boot_ff  <= 1'b0;
			led_err_ff   <= 1'b0;
		end else begin
			led_can_ff   <= mcs_pkg::led_level(can_mode, blink_ff);
			led_rs485_ff <= mcs_pkg::led_level(rs485_mode, blink_ff);
			led_run_ff   <= mcs_pkg::led_level(run_mode, blink_ff);
			led_boot_ff  <= boot_done_in;
			led_err_ff   <= mcs_pkg::led_level(err_mode, blink_ff);
		end
	end

	// Outputs
	assign rdata_out        = rdata_ff;
	assign pwr_en_out       = pwr_en_ff;
	assign wdog_expired_out = expired_ff;
	assign led_can_out      = led_can_ff;
	assign led_rs485_out    = led_rs485_ff;
	assign led_run_out      = led_run_ff;
	assign led_boot_out     = led_boot_ff;
	assign led_err_out      = led_err_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	service_restart_a: assert property (
		(wd_st_ff == mcs_pkg::WD_RUN) && host_read_service &&
		ctrl_ff[mcs_pkg::CTRL_WDOG_EN] |=> wd_cnt_ff == 32'h0000_0000)
		else $error("service read did not restart the watchdog");

	expiry_cause_a: assert property (
		$rose(wdog_expired_out) |-> $past(wd_cnt_ff) >= $past(timeout_ff))
		else $error("expired flag rose before the timeout");

	overrun_power_a: assert property (
		wdog_expired_out |-> pwr_en_out == '0)
		else $error("power enable high while watchdog expired");

	gate_enable_a: assert property (
		!ctrl_ff[mcs_pkg::CTRL_WDOG_EN] |=> ##1 !wdog_expired_out)
		else $error("expired flag set with watchdog disabled");

	power_cause_a: assert property (
		pwr_en_out[0] |-> $past(ctrl_ff[mcs_pkg::CTRL_PWR_REQ]) &&
		!$past(pwr_fault_in))
		else $error("power enable without request or with fault");

	error_lamp_a: assert property (
		wd_st_ff == mcs_pkg::WD_EXP |=> led_err_out)
		else $error("error lamp not steady on after expiry");

	can_full_a: assert property (
		can_buf_full_in |=> led_can_out)
		else $error("CAN lamp not on with full buffer");

	rs485_drop_a: assert property (
		|node_dropped |=> !led_rs485_out)
		else $error("RS485 lamp lit with a dropped node");

	switch_inv_a: assert property (
		rd_in && addr_in == mcs_pkg::REG_SW_INV |=>
		rdata_out[mcs_pkg::SW_BITS-1:0] == ~$past(sw_snap_ff))
		else $error("inverted switch word wrong");

	expired_latch_a: assert property (
		wdog_expired_out && ctrl_ff[mcs_pkg::CTRL_WDOG_EN] &&
		$past(ctrl_ff[mcs_pkg::CTRL_WDOG_EN]) |-> $past(wdog_expired_out) ||
		$past(wd_st_ff) == mcs_pkg::WD_RUN)
		else $error("expired flag appeared outside a running watchdog");

endmodule // mcs_supervisor

// *** bench/mcs_host_model.sv ***
// Host driver model: register cycles and periodic service reads
`timescale 1ns/10ps
module mcs_host_model (
	// Clock
	input  wire logic                       clk_sys_in,
	// Register port
	output logic [mcs_pkg::ADDR_W-1:0]      addr_out,
	output logic [mcs_pkg::DATA_W-1:0]      wdata_out,
	output logic                            wr_out,
	output logic                            rd_out
);
	// Expected read notes: mask in the upper half, value below
	logic [63:0] exp_q[$];

	initial begin
		addr_out = 8'h00;
		wdata_out = 32'h0000_0000;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge clk_sys_in);
		wr_out <= 1'h0;
	endtask

	// One-cycle read strobe, expectation noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		@(posedge clk_sys_in);
		addr_out <= a;
		rd_out <= 1'h1;
		exp_q.push_back({m, e & m});
		@(posedge clk_sys_in);
		rd_out <= 1'h0;
	endtask

	// Service thread: timeout is kept near three of its periods
	task automatic service(input int n, input int per);
		repeat (n) begin
			rd(mcs_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_0000);
			repeat (per - 2) @(posedge clk_sys_in);
		end
	endtask
endmodule // mcs_host_model

// *** bench/tb_top.sv ***
// Self-checking bench of the motion card safety supervisor
`timescale 1ns/10ps
module tb_top;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        clk_sys_in = 1'h0;
	logic        nrst_in = 1'h0;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v;
	logic        wr, rd;
	logic        rd_d = 1'h0;
	logic [5:0]  low_l = 6'h00, high_l = 6'h00, org_l = 6'h00;
	logic [1:0]  estop = 2'h0;
	logic        pwr_fault = 1'h0, pci_err = 1'h0, boot_done = 1'h0;
	logic        init_busy = 1'h0;
	logic        can_frame = 1'h0, can_full = 1'h0;
	logic [15:0] answer = 16'h0000;
	logic [6:0]  pwr_en;
	logic        expired, led_can, led_rs, led_run, led_boot, led_err;
	logic [17:0] sw;
	logic [63:0] note;
	int          failures = 0, samples_checked = 0, seed = 13, hi = 0;

	always #2 clk_sys_in = ~clk_sys_in;

	mcs_host_model i_host (.clk_sys_in(clk_sys_in), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	mcs_supervisor #(.BLINK_CYC(4), .CAN_IDLE_CYC(8), .NODE_DROP_CYC(8))
	i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.low_travel_limit_level_in(low_l), .high_travel_limit_level_in(high_l),
		.origin_switch_level_in(org_l), .estop_level_in(estop),
		.pwr_fault_in(pwr_fault), .pci_err_in(pci_err),
		.can_frame_in(can_frame), .can_buf_full_in(can_full),
		.boot_done_in(boot_done),
		.node_init_busy_in(init_busy), .node_answer_in(answer),
		.pwr_en_out(pwr_en), .wdog_expired_out(expired),
		.led_can_out(led_can), .led_rs485_out(led_rs), .led_run_out(led_run),
		.led_boot_out(led_boot), .led_err_out(led_err));

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Read data stands in the cycle after the strobe
	always @(posedge clk_sys_in) begin
		if (rd_d && i_host.exp_q.size() > 0) begin
			note = i_host.exp_q.pop_front();
			chk("rdata", rdata & note[63:32], note[31:0]);
		end
		rd_d <= rd;
	end

	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	initial begin
		#20000;
		failures++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys_in);
		nrst_in <= 1'h1;
		i_host.rd(mcs_pkg::REG_CTRL, 32'h0000_0000, ALL);
		i_host.rd(mcs_pkg::REG_TIMEOUT, mcs_pkg::TIMEOUT_RST, ALL);
		i_host.rd(8'h1C, 32'h0000_0000, ALL);
		i_host.wr(mcs_pkg::REG_TIMEOUT, 32'h0000_001E);
		i_host.wr(mcs_pkg::REG_CTRL, 32'h0000_0003);
		v = $random(seed);
		low_l <= v[5:0];
		high_l <= v[11:6];
		org_l <= v[17:12];
		estop <= v[19:18];
		for (int j = 0; j < 6; j++) sw[3*j +: 3] = {v[12+j], v[6+j], v[j]};
		i_host.rd(mcs_pkg::REG_STATUS, 32'h0000_0002, ALL);
		i_host.rd(mcs_pkg::REG_SW_TRUE, {14'h0000, sw}, ALL);
		i_host.rd(mcs_pkg::REG_SW_INV, {14'h0000, ~sw}, ALL);
		i_host.rd(mcs_pkg::REG_ESTOP, {28'h0, ~v[19:18], v[19:18]}, ALL);
		chk("pwr_en", {25'h0, pwr_en}, 32'h7F);
		i_host.service(20, 10);
		chk("expired", {31'h0, expired}, 32'h0);
		repeat (20) @(posedge clk_sys_in);
		chk("expired", {31'h0, expired}, 32'h0);
		repeat (25) @(posedge clk_sys_in);
		chk("expired", {31'h0, expired}, 32'h1);
		chk("pwr_en", {25'h0, pwr_en}, 32'h0);
		chk("led_err", {31'h0, led_err}, 32'h1);
		i_host.rd(mcs_pkg::REG_STATUS, 32'h1, 32'h1);
		i_host.service(3, 10);
		chk("expired", {31'h0, expired}, 32'h1);
		i_host.wr(mcs_pkg::REG_CTRL, 32'h0000_0002);
		repeat (4) @(posedge clk_sys_in);
		chk("expired", {31'h0, expired}, 32'h0);
		chk("pwr_en", {25'h0, pwr_en}, 32'h7F);
		chk("led_err", {31'h0, led_err}, 32'h0);
		pwr_fault <= 1'h1;
		repeat (3) @(posedge clk_sys_in);
		chk("pwr_en", {25'h0, pwr_en}, 32'h0);
		pwr_fault <= 1'h0;
		pci_err <= 1'h1;
		@(posedge clk_sys_in);
		pci_err <= 1'h0;
		repeat (24) @(posedge clk_sys_in) hi += led_err;
		chk("err_blink", {31'h0, hi > 0 && hi < 24}, 32'h1);
		i_host.rd(mcs_pkg::REG_STATUS, 32'h8, 32'h8);
		i_host.wr(mcs_pkg::REG_STATUS, 32'h0000_0008);
		i_host.rd(mcs_pkg::REG_STATUS, 32'h0, 32'h8);
		// CAN lamp: full buffer, then one frame, then idle
		can_full <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		chk("led_can", {31'h0, led_can}, 32'h1);
		can_full <= 1'h0;
		can_frame <= 1'h1;
		@(posedge clk_sys_in);
		can_frame <= 1'h0;
		hi = 0;
		repeat (12) @(posedge clk_sys_in) hi += led_can;
		chk("can_blink", {31'h0, hi > 0 && hi < 12}, 32'h1);
		repeat (2) @(posedge clk_sys_in);
		chk("led_can", {31'h0, led_can}, 32'h0);
		boot_done <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		chk("led_boot", {31'h0, led_boot}, 32'h1);
		init_busy <= 1'h1;
		hi = 0;
		repeat (12) @(posedge clk_sys_in) hi += led_rs;
		chk("rs485_blink", {31'h0, hi > 0 && hi < 12}, 32'h1);
		answer <= 16'h0020;
		@(posedge clk_sys_in);
		answer <= 16'h0000;
		init_busy <= 1'h0;
		i_host.rd(mcs_pkg::REG_NODES, 32'h0000_0020, ALL);
		chk("led_rs485", {31'h0, led_rs}, 32'h1);
		repeat (15) @(posedge clk_sys_in);
		i_host.rd(mcs_pkg::REG_NODES, 32'h0020_0000, ALL);
		chk("led_rs485", {31'h0, led_rs}, 32'h0);
		// Run lamp blinks while the run bit is set
		i_host.wr(mcs_pkg::REG_CTRL, 32'h0000_0006);
		hi = 0;
		repeat (12) @(posedge clk_sys_in) hi += led_run;
		chk("run_blink", {31'h0, hi > 0 && hi < 12}, 32'h1);
		repeat (3) @(posedge clk_sys_in);
		print_verdict();
	end
endmodule // tb_top
